// *** hdl/i2c_packet_master.sv ***
// top of the packet driven i2c master: bit engine on the system clock
// assumes open drain lines with pull-ups and a link clock from the host
// Notes on behaviour
// - send count field sets bytes written
// - option bit 1 resets bus first
// - option bit 4 waits for released scl
// - option bit 2 restarts without stop
// - larger slowdown value gives slower scl
// - two selectors route sda, scl lines
// - address byte goes out first
// - address bit 0 replaced by direction
// - write exactly 0 to 50 payload bytes
// - read exactly 0 to 52 bytes
// - response length three plus padded words
// - 32-bit record of acknowledged writes
// - record bit 0 is last byte
// - payload from byte 14, reads at 12
`timescale 1ns/1ps
module i2c_packet_master
(
  // system clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // packet link
  input wire logic linkClk,
  input wire logic [7:0] cmdByte,
  input wire logic cmdValid,
  input wire logic cmdLast,
  output logic cmdReady,
  output logic [7:0] respByte,
  output logic respValid,
  output logic respLast,
  input wire logic respReady,
  // general digital lines, open drain
  input wire logic [i2c_cmd_pkg::NUM_LINES-1:0] lineIn,
  output logic [i2c_cmd_pkg::NUM_LINES-1:0] lineOut,
  output logic [i2c_cmd_pkg::NUM_LINES-1:0] lineOe,
  // status
  output logic busy
);
  // ----------------------------------------------------------------
  // link port
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b000,
    ST_CHECK = 3'b001,
    ST_RSTBUS = 3'b010,
    ST_START = 3'b011,
    ST_BIT = 3'b100,
    ST_STOP = 3'b101,
    ST_DONE = 3'b110
  } state_e;

  logic reqTgl;
  i2c_cmd_pkg::cmd_s cmd;
  logic [5:0] byteCnt_ff, nxt_byteCnt;
  logic [7:0] payByte;
  logic doneTgl_ff;
  i2c_cmd_pkg::result_s result;
  logic [i2c_cmd_pkg::MAX_RD*8-1:0] rdFlat;
  logic [31:0] ack_ff, nxt_ack;
  logic [7:0] err_ff, nxt_err;

  assign result = '{err: err_ff, ackRecord: ack_ff};

  link_packet_port u_link
  (
    .linkClk(linkClk),
    .rstn(rstn),
    .cmdByte(cmdByte),
    .cmdValid(cmdValid),
    .cmdLast(cmdLast),
    .cmdReady(cmdReady),
    .respByte(respByte),
    .respValid(respValid),
    .respLast(respLast),
    .respReady(respReady),
    .reqTgl(reqTgl),
    .cmdInfo(cmd),
    .payIdx(byteCnt_ff),
    .payByte(payByte),
    .doneTgl(doneTgl_ff),
    .result(result),
    .rdFlat(rdFlat)
  );

  // ----------------------------------------------------------------
  // crossings: request toggle and line inputs
  // ----------------------------------------------------------------
  logic reqS1_ff, reqS2_ff, reqS3_ff;
  logic [i2c_cmd_pkg::NUM_LINES-1:0] pinS1_ff, pinS2_ff;
  wire reqEdge = reqS2_ff ^ reqS3_ff;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      reqS1_ff <= 1'b0;
      reqS2_ff <= 1'b0;
      reqS3_ff <= 1'b0;
      pinS1_ff <= '1;
      pinS2_ff <= '1;
    end
    else
    begin
      reqS1_ff <= reqTgl;
      reqS2_ff <= reqS1_ff;
      reqS3_ff <= reqS2_ff;
      pinS1_ff <= lineIn;
      pinS2_ff <= pinS1_ff;
    end
  end

  // ----------------------------------------------------------------
  // decode of the held command
  // ----------------------------------------------------------------
  // command fields are only read while the link side is busy and holds them
  wire [4:0] sdaSel = cmd.dataSel[4:0];
  wire [4:0] sclSel = cmd.clockSel[4:0];
  wire selBad = cmd.dataSel >= 8'(i2c_cmd_pkg::NUM_LINES)
             || cmd.clockSel >= 8'(i2c_cmd_pkg::NUM_LINES)
             || cmd.dataSel == cmd.clockSel;
  wire cntBad = cmd.code != i2c_cmd_pkg::CMD_CODE
             || cmd.wrCount > 8'(i2c_cmd_pkg::MAX_WR)
             || cmd.rdCount > 8'(i2c_cmd_pkg::MAX_RD);
  wire sdaIn = selBad ? 1'b1 : pinS2_ff[sdaSel];
  wire sclIn = selBad ? 1'b1 : pinS2_ff[sclSel];
  wire stretchOn = cmd.options[i2c_cmd_pkg::OPT_STRETCH];
  wire [5:0] wrCount = cmd.wrCount[5:0];
  wire [5:0] rdCount = cmd.rdCount[5:0];

  // ----------------------------------------------------------------
  // quarter period timer
  // ----------------------------------------------------------------
  // one bit is four quarters; step of 15/4 quarter cycles per unit
  logic [11:0] quarterCnt_ff;
  wire [11:0] quarterLoad = 12'(i2c_cmd_pkg::QUARTER_BASE)
    + ((12'(cmd.slowdown) * 12'(i2c_cmd_pkg::SLOW_STEP_X4)) >> 2);
  wire tick = quarterCnt_ff == 12'h000;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      quarterCnt_ff <= 12'h000;
    else
      quarterCnt_ff <= tick ? quarterLoad : quarterCnt_ff - 12'h001;
  end

  // ----------------------------------------------------------------
  // bit engine
  // ----------------------------------------------------------------
  state_e state_ff, nxt_state;
  logic [1:0] phase_ff;
  logic [3:0] bitIdx_ff, nxt_bitIdx;
  logic [7:0] shift_ff, nxt_shift;
  logic sdaLow_ff, nxt_sdaLow, sclLow_ff, nxt_sclLow;
  logic readPhase_ff, nxt_readPhase, addrByte_ff, nxt_addrByte;
  logic pendStart_ff, nxt_pendStart, ackBit_ff, nxt_ackBit;
  logic rdWe;

  wire active = state_ff == ST_RSTBUS || state_ff == ST_START
             || state_ff == ST_BIT || state_ff == ST_STOP;
  // a slave holding scl low freezes the quarter after scl is released
  wire hold = stretchOn && phase_ff == 2'd2 && !sclIn;
  wire step = active && tick && !hold;
  wire reading = readPhase_ff && !addrByte_ff;
  wire lastRead = byteCnt_ff + 6'h01 == rdCount;
  wire [7:0] addrOut = {cmd.address[7:1], readPhase_ff};
  wire moreWrite = !readPhase_ff && byteCnt_ff < wrCount;
  wire goRead = !readPhase_ff && rdCount != 6'h00;
  wire ackDrive = reading ? !lastRead : 1'b0;
  wire bitDrive = (bitIdx_ff == 4'h8) ? ackDrive
                : (!reading && !shift_ff[7]);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_bitIdx = bitIdx_ff;
    nxt_shift = shift_ff;
    nxt_sdaLow = sdaLow_ff;
    nxt_sclLow = sclLow_ff;
    nxt_readPhase = readPhase_ff;
    nxt_addrByte = addrByte_ff;
    nxt_pendStart = pendStart_ff;
    nxt_ackBit = ackBit_ff;
    nxt_byteCnt = byteCnt_ff;
    nxt_ack = ack_ff;
    nxt_err = err_ff;
    rdWe = 1'b0;
    unique case (state_ff)
      ST_IDLE:
        if (reqEdge)
          nxt_state = ST_CHECK;
      ST_CHECK:
      begin
        nxt_ack = 32'h0000_0000;
        nxt_byteCnt = 6'h00;
        nxt_bitIdx = 4'h0;
        nxt_err = selBad ? i2c_cmd_pkg::ERR_INVALID_PIN
                : cntBad ? i2c_cmd_pkg::ERR_BAD_REQUEST
                : i2c_cmd_pkg::ERR_NONE;
        // an empty write phase goes straight to the read address
        nxt_readPhase = wrCount == 6'h00 && rdCount != 6'h00;
        nxt_pendStart = cmd.options[i2c_cmd_pkg::OPT_BUS_RESET];
        if (selBad || cntBad)
          nxt_state = ST_DONE;
        else if (cmd.options[i2c_cmd_pkg::OPT_BUS_RESET])
          nxt_state = ST_RSTBUS;
        else
          nxt_state = ST_START;
      end
      ST_RSTBUS:
        if (step)
        begin
          nxt_sdaLow = 1'b0;
          nxt_sclLow = phase_ff != 2'd1;
          if (phase_ff == 2'd3)
          begin
            nxt_bitIdx = bitIdx_ff + 4'h1;
            if (bitIdx_ff == i2c_cmd_pkg::BUS_RESET_CLOCKS - 4'h1)
            begin
              nxt_bitIdx = 4'h0;
              nxt_state = ST_STOP;
            end
          end
        end
      ST_START:
        if (step)
        begin
          unique case (phase_ff)
            2'd0: nxt_sdaLow = 1'b0;
            2'd1: nxt_sclLow = 1'b0;
            2'd2: nxt_sdaLow = 1'b1;
            2'd3:
            begin
              nxt_sclLow = 1'b1;
              nxt_shift = addrOut;
              nxt_addrByte = 1'b1;
              nxt_bitIdx = 4'h0;
              nxt_state = ST_BIT;
            end
          endcase
        end
      ST_BIT:
        if (step)
        begin
          unique case (phase_ff)
            2'd0: nxt_sdaLow = bitDrive;
            2'd1: nxt_sclLow = 1'b0;
            2'd2:
              if (bitIdx_ff == 4'h8)
                nxt_ackBit = !sdaIn;
              else
                nxt_shift = {shift_ff[6:0], sdaIn};
            2'd3:
            begin
              nxt_sclLow = 1'b1;
              nxt_bitIdx = bitIdx_ff + 4'h1;
              if (bitIdx_ff == 4'h8)
              begin
                nxt_bitIdx = 4'h0;
                nxt_addrByte = 1'b0;
                if (!readPhase_ff)
                  nxt_ack = {ack_ff[30:0], ackBit_ff};
                if (moreWrite)
                begin
                  nxt_shift = payByte;
                  nxt_byteCnt = byteCnt_ff + 6'h01;
                end
                else if (goRead)
                begin
                  nxt_readPhase = 1'b1;
                  nxt_byteCnt = 6'h00;
                  if (cmd.options[i2c_cmd_pkg::OPT_NO_STOP])
                    nxt_state = ST_START;
                  else
                  begin
                    nxt_pendStart = 1'b1;
                    nxt_state = ST_STOP;
                  end
                end
                else if (reading)
                begin
                  rdWe = 1'b1;
                  nxt_byteCnt = byteCnt_ff + 6'h01;
                  if (lastRead)
                    nxt_state = ST_STOP;
                end
                else if (!addrByte_ff || !readPhase_ff)
                  nxt_state = ST_STOP;
              end
            end
          endcase
        end
      ST_STOP:
        if (step)
        begin
          unique case (phase_ff)
            2'd0:
            begin
              nxt_sdaLow = 1'b1;
              nxt_sclLow = 1'b1;
            end
            2'd1: nxt_sclLow = 1'b0;
            2'd2: nxt_sdaLow = 1'b0;
            2'd3:
            begin
              nxt_pendStart = 1'b0;
              nxt_state = pendStart_ff ? ST_START : ST_DONE;
            end
          endcase
        end
      ST_DONE:
        nxt_state = ST_IDLE;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff <= ST_IDLE;
      phase_ff <= 2'd0;
      bitIdx_ff <= 4'h0;
      shift_ff <= 8'h00;
      sdaLow_ff <= 1'b0;
      sclLow_ff <= 1'b0;
      readPhase_ff <= 1'b0;
      addrByte_ff <= 1'b0;
      pendStart_ff <= 1'b0;
      ackBit_ff <= 1'b0;
      byteCnt_ff <= 6'h00;
      ack_ff <= 32'h0000_0000;
      err_ff <= i2c_cmd_pkg::ERR_NONE;
      doneTgl_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      phase_ff <= (nxt_state != state_ff) ? 2'd0
                : step ? phase_ff + 2'd1 : phase_ff;
      bitIdx_ff <= nxt_bitIdx;
      shift_ff <= nxt_shift;
      sdaLow_ff <= nxt_sdaLow;
      sclLow_ff <= nxt_sclLow;
      readPhase_ff <= nxt_readPhase;
      addrByte_ff <= nxt_addrByte;
      pendStart_ff <= nxt_pendStart;
      ackBit_ff <= nxt_ackBit;
      byteCnt_ff <= nxt_byteCnt;
      ack_ff <= nxt_ack;
      err_ff <= nxt_err;
      doneTgl_ff <= doneTgl_ff ^ (state_ff == ST_DONE);
    end
  end

  // ----------------------------------------------------------------
  // read buffer and line drivers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < i2c_cmd_pkg::MAX_RD; i++)
  begin : g_rd
    always_ff @(posedge clk_sys or negedge rstn)
    begin
      if (!rstn)
        rdFlat[i*8 +: 8] <= 8'h00;
      else if (rdWe && byteCnt_ff == 6'(i))
        rdFlat[i*8 +: 8] <= shift_ff;
    end
  end

  logic [i2c_cmd_pkg::NUM_LINES-1:0] lineOe_ff;

  for (genvar i = 0; i < i2c_cmd_pkg::NUM_LINES; i++)
  begin : g_line
    always_ff @(posedge clk_sys or negedge rstn)
    begin
      if (!rstn)
        lineOe_ff[i] <= 1'b0;
      else
        lineOe_ff[i] <= !selBad && ((sdaSel == 5'(i) && sdaLow_ff)
                     || (sclSel == 5'(i) && sclLow_ff));
    end
  end

  // lines are only ever pulled low; the pull-ups make the high level
  assign lineOut = '0;
  assign lineOe = lineOe_ff;
  assign busy = state_ff != ST_IDLE;
endmodule : i2c_packet_master

// *** common/i2c_cmd_pkg.sv ***
// package for the packet driven i2c master: packet layout, counts, codes
// assumes a 40 MHz system clock and a byte wide packet link
package i2c_cmd_pkg;
  // ----------------------------------------------------------------
  // packet layout
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_CODE = 8'h3B;
  localparam logic [7:0] FRAME_MARK = 8'hF8;
  localparam int CMD_OFS_LEN = 2;
  localparam int CMD_OFS_CODE = 3;
  localparam int CMD_OFS_OPT = 6;
  localparam int CMD_OFS_SLOW = 7;
  localparam int CMD_OFS_SDA = 8;
  localparam int CMD_OFS_SCL = 9;
  localparam int CMD_OFS_ADDR = 10;
  localparam int CMD_OFS_WRCNT = 12;
  localparam int CMD_OFS_RDCNT = 13;
  localparam int CMD_OFS_PAYLOAD = 14;
  localparam int RSP_OFS_ERR = 6;
  localparam int RSP_OFS_ACK = 8;
  localparam int RSP_OFS_DATA = 12;
  localparam logic [7:0] RSP_BASE_LEN = 8'h03;
  // ----------------------------------------------------------------
  // option bits, limits, error codes
  // ----------------------------------------------------------------
  localparam int OPT_BUS_RESET = 1;
  localparam int OPT_NO_STOP = 2;
  localparam int OPT_STRETCH = 4;
  localparam int MAX_WR = 50;
  localparam int MAX_RD = 52;
  localparam int NUM_LINES = 20;
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_BAD_REQUEST = 8'h05;
  localparam logic [7:0] ERR_INVALID_PIN = 8'h60;
  localparam logic [3:0] BUS_RESET_CLOCKS = 4'h9;
  // ----------------------------------------------------------------
  // scl timing
  // ----------------------------------------------------------------
  localparam int SYS_HZ = 40_000_000;
  localparam int SCL_BASE_KHZ = 150;
  localparam int QUARTER_BASE = SYS_HZ / (SCL_BASE_KHZ * 1000 * 4);
  localparam int SLOW_STEP_X4 = 15;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef logic [7:0] byte_t;
  typedef struct packed {
    byte_t code;
    byte_t options;
    byte_t slowdown;
    byte_t dataSel;
    byte_t clockSel;
    byte_t address;
    byte_t wrCount;
    byte_t rdCount;
  } cmd_s;
  typedef struct packed {
    byte_t err;
    logic [31:0] ackRecord;
  } result_s;
endpackage : i2c_cmd_pkg

// *** hdl/link_packet_port.sv ***
// link side of the i2c master: takes command packets, returns responses
// runs on the link clock; sys side reads held fields under a toggle handshake
`timescale 1ns/1ps
module link_packet_port
(
  // link clock and reset
  input wire logic linkClk,
  input wire logic rstn,
  // command stream
  input wire logic [7:0] cmdByte,
  input wire logic cmdValid,
  input wire logic cmdLast,
  output logic cmdReady,
  // response stream
  output logic [7:0] respByte,
  output logic respValid,
  output logic respLast,
  input wire logic respReady,
  // toward the system domain
  output logic reqTgl,
  output i2c_cmd_pkg::cmd_s cmdInfo,
  input wire logic [5:0] payIdx,
  output logic [7:0] payByte,
  input wire logic doneTgl,
  input wire i2c_cmd_pkg::result_s result,
  input wire logic [i2c_cmd_pkg::MAX_RD*8-1:0] rdFlat
);
  // ----------------------------------------------------------------
  // command capture
  // ----------------------------------------------------------------
  logic [6:0] rxIdx_ff;
  logic busy_ff;
  logic reqTgl_ff;
  i2c_cmd_pkg::cmd_s cmd_ff;
  logic [7:0] pay_ff [i2c_cmd_pkg::MAX_WR];
  wire take = cmdValid && !busy_ff;
  wire [6:0] payOfs = rxIdx_ff - 7'(i2c_cmd_pkg::CMD_OFS_PAYLOAD);

  // a new packet is refused until the last response byte is taken
  assign cmdReady = !busy_ff;
  assign reqTgl = reqTgl_ff;
  assign cmdInfo = cmd_ff;
  assign payByte = (payIdx < 6'(i2c_cmd_pkg::MAX_WR)) ? pay_ff[payIdx]
                                                     : 8'h00;

  always_ff @(posedge linkClk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxIdx_ff <= 7'h00;
      reqTgl_ff <= 1'b0;
      cmd_ff <= '0;
    end
    else if (take)
    begin
      rxIdx_ff <= cmdLast ? 7'h00 : rxIdx_ff + 7'h01;
      reqTgl_ff <= reqTgl_ff ^ cmdLast;
      case (rxIdx_ff)
        7'(i2c_cmd_pkg::CMD_OFS_CODE): cmd_ff.code <= cmdByte;
        7'(i2c_cmd_pkg::CMD_OFS_OPT): cmd_ff.options <= cmdByte;
        7'(i2c_cmd_pkg::CMD_OFS_SLOW): cmd_ff.slowdown <= cmdByte;
        7'(i2c_cmd_pkg::CMD_OFS_SDA): cmd_ff.dataSel <= cmdByte;
        7'(i2c_cmd_pkg::CMD_OFS_SCL): cmd_ff.clockSel <= cmdByte;
        7'(i2c_cmd_pkg::CMD_OFS_ADDR): cmd_ff.address <= cmdByte;
        7'(i2c_cmd_pkg::CMD_OFS_WRCNT): cmd_ff.wrCount <= cmdByte;
        7'(i2c_cmd_pkg::CMD_OFS_RDCNT): cmd_ff.rdCount <= cmdByte;
        default: cmd_ff <= cmd_ff;
      endcase
    end
  end

  for (genvar i = 0; i < i2c_cmd_pkg::MAX_WR; i++)
  begin : g_pay
    always_ff @(posedge linkClk or negedge rstn)
    begin
      if (!rstn)
        pay_ff[i] <= 8'h00;
      else if (take && rxIdx_ff >= 7'(i2c_cmd_pkg::CMD_OFS_PAYLOAD)
               && payOfs == 7'(i))
        pay_ff[i] <= cmdByte;
    end
  end

  // ----------------------------------------------------------------
  // done crossing and response build
  // ----------------------------------------------------------------
  logic doneS1_ff, doneS2_ff, doneS3_ff;
  logic [6:0] txIdx_ff;
  logic [7:0] respByte_ff;
  logic respValid_ff;
  wire doneEdge = doneS2_ff ^ doneS3_ff;
  wire [7:0] effRd = (result.err != i2c_cmd_pkg::ERR_NONE) ? 8'h00
                                                           : cmd_ff.rdCount;
  wire [6:0] words = 7'((effRd + 8'h01) >> 1);
  wire [6:0] total = 7'(i2c_cmd_pkg::RSP_OFS_DATA) + {words[5:0], 1'b0};
  wire [7:0] lenByte = i2c_cmd_pkg::RSP_BASE_LEN + {1'b0, words};
  wire advance = respValid_ff && respReady;
  wire [6:0] nxtIdx = doneEdge ? 7'h00 : txIdx_ff + 7'h01;
  wire [6:0] dataOfs = nxtIdx - 7'(i2c_cmd_pkg::RSP_OFS_DATA);
  logic [15:0] bodySum;
  logic [7:0] hdrSum;
  logic [7:0] nxtByte;

  // zero padding past the read count keeps an odd count word aligned
  always_comb
  begin
    bodySum = 16'(result.err) + 16'(result.ackRecord[7:0])
            + 16'(result.ackRecord[15:8]) + 16'(result.ackRecord[23:16])
            + 16'(result.ackRecord[31:24]);
    for (int k = 0; k < i2c_cmd_pkg::MAX_RD; k++)
      if (k < int'(effRd))
        bodySum = bodySum + 16'(rdFlat[k*8 +: 8]);
    hdrSum = i2c_cmd_pkg::FRAME_MARK + lenByte + i2c_cmd_pkg::CMD_CODE
           + bodySum[7:0] + bodySum[15:8];
  end

  always_comb
  begin
    case (nxtIdx)
      7'h00: nxtByte = hdrSum;
      7'h01: nxtByte = i2c_cmd_pkg::FRAME_MARK;
      7'h02: nxtByte = lenByte;
      7'h03: nxtByte = i2c_cmd_pkg::CMD_CODE;
      7'h04: nxtByte = bodySum[7:0];
      7'h05: nxtByte = bodySum[15:8];
      7'(i2c_cmd_pkg::RSP_OFS_ERR): nxtByte = result.err;
      7'h07: nxtByte = 8'h00;
      7'h08: nxtByte = result.ackRecord[7:0];
      7'h09: nxtByte = result.ackRecord[15:8];
      7'h0A: nxtByte = result.ackRecord[23:16];
      7'h0B: nxtByte = result.ackRecord[31:24];
      default: nxtByte = ({1'b0, dataOfs} < effRd)
                         ? rdFlat[dataOfs*8 +: 8] : 8'h00;
    endcase
  end

  assign respByte = respByte_ff;
  assign respValid = respValid_ff;
  assign respLast = respValid_ff && (txIdx_ff == total - 7'h01);

  always_ff @(posedge linkClk or negedge rstn)
  begin
    if (!rstn)
    begin
      doneS1_ff <= 1'b0;
      doneS2_ff <= 1'b0;
      doneS3_ff <= 1'b0;
      txIdx_ff <= 7'h00;
      respByte_ff <= 8'h00;
      respValid_ff <= 1'b0;
      busy_ff <= 1'b0;
    end
    else
    begin
      doneS1_ff <= doneTgl;
      doneS2_ff <= doneS1_ff;
      doneS3_ff <= doneS2_ff;
      if (take && cmdLast)
        busy_ff <= 1'b1;
      if (doneEdge || (advance && !respLast))
      begin
        txIdx_ff <= nxtIdx;
        respByte_ff <= nxtByte;
        respValid_ff <= 1'b1;
      end
      else if (advance)
      begin
        respValid_ff <= 1'b0;
        busy_ff <= 1'b0;
      end
    end
  end
endmodule : link_packet_port

// *** tb/i2c_slave_model.sv ***
// i2c slave model: acks its address and writes, reads out a5 upward
// assumes the bench resolves open drain lines with pull-ups
`timescale 1ns/1ps
module i2c_slave_model
(
  // line levels
  input wire logic scl,
  input wire logic sda,
  input wire logic stretch,
  // pull-downs, high pulls the line low
  output logic pull,
  output logic hold
);
  logic [7:0] sh, tx, last;
  logic [3:0] n;
  logic on, adr, rd, hit;
  int wrN = 0;
  initial {pull, hold, on, n} = 7'h00;
  always @(negedge sda) if (scl === 1'b1) {on, adr, rd, n, tx} = 15'h60A5;
  always @(posedge sda) if (scl === 1'b1) {on, pull} = 2'h0;
  always @(posedge scl) if (on)
  begin
    n = n + 4'h1;
    if (n < 4'h9) sh = {sh[6:0], sda};
    else if (rd && sda) on = 1'b0;
  end
  always @(negedge scl) if (on)
  begin
    if (n == 4'h8) pull = !rd && (adr ? sh[7:1] == 7'h50 : hit);
    if (n == 4'h9)
    begin
      {n, pull} = 5'h00;
      if (adr) hit = sh[7:1] == 7'h50;
      if (adr) rd = hit && sh[0];
      else if (rd) tx = tx + 8'h01;
      else if (hit) wrN = wrN + 1;
      if (!adr && !rd && hit) last = sh;
      adr = 1'b0;
    end
    if (rd && n < 4'h8) pull = !tx[3'h7 - n[2:0]];
  end
  // fixed 4 us per low phase; real parts may hold far longer
  always @(negedge scl) if (stretch)
  begin
    hold = 1'b1;
    #4000 hold = 1'b0;
  end
endmodule : i2c_slave_model

// *** tb/i2c_packet_master_sva.sv ***
// checker for the i2c packet master top ports
// assumes rstn clears both clock domains
`timescale 1ns/1ps
module i2c_packet_master_sva
(
  // clocks, reset
  input wire logic clk_sys,
  input wire logic linkClk,
  input wire logic rstn,
  // link
  input wire logic cmdValid,
  input wire logic cmdLast,
  input wire logic cmdReady,
  input wire logic [7:0] respByte,
  input wire logic respValid,
  input wire logic respLast,
  input wire logic respReady,
  // lines, status
  input wire logic [i2c_cmd_pkg::NUM_LINES-1:0] lineOut,
  input wire logic [i2c_cmd_pkg::NUM_LINES-1:0] lineOe,
  input wire logic busy
);
  // ------------------------------------------
  // properties
  // ------------------------------------------
  property p_hold; @(posedge linkClk) disable iff (!rstn)
    respValid && !respReady |=> respValid && $stable(respByte); endproperty
  a_hold: assert property (p_hold) else $error("resp moved");
  property p_take; @(posedge linkClk) disable iff (!rstn)
    respValid && respReady && respLast |=> !respValid && cmdReady; endproperty
  a_take: assert property (p_take) else $error("resp end");
  property p_block; @(posedge linkClk) disable iff (!rstn)
    cmdValid && cmdReady && cmdLast |=> !cmdReady; endproperty
  a_block: assert property (p_block) else $error("cmd end");
  property p_quiet; @(posedge linkClk) disable iff (!rstn)
    respValid |-> !cmdReady; endproperty
  a_quiet: assert property (p_quiet) else $error("ready early");
  property p_busy; @(posedge clk_sys) disable iff (!rstn)
    busy |-> !cmdReady; endproperty
  a_busy: assert property (p_busy) else $error("ready busy");
  property p_drv; @(posedge clk_sys) disable iff (!rstn)
    lineOut == '0; endproperty
  a_drv: assert property (p_drv) else $error("line driven");
  property p_two; @(posedge clk_sys) disable iff (!rstn)
    $countones(lineOe) <= 2; endproperty
  a_two: assert property (p_two) else $error("lines");
  property p_idle; @(posedge clk_sys) disable iff (!rstn)
    !busy [*3] |-> lineOe == '0; endproperty
  a_idle: assert property (p_idle) else $error("idle pull");
  c_resp: cover property (@(posedge linkClk) respLast && respReady);
  c_two: cover property (@(posedge clk_sys) $countones(lineOe) == 2);
  c_busy: cover property (@(posedge clk_sys) $fell(busy));
endmodule : i2c_packet_master_sva

bind i2c_packet_master i2c_packet_master_sva chk (.*);

// *** tb/i2c_packet_master_tb_top.sv ***
// bench for the i2c packet master: fixed and random transactions
// assumes one slave model on the selected lines, pull-ups on all
`timescale 1ns/1ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin bad_count++; \
$display("mismatch %s exp %h got %h", n, e, g); end end
module i2c_packet_master_tb_top;
  logic clk_sys = 0;
  logic linkClk = 0;
  logic rstn = 0;
  logic cmdValid = 0;
  logic cmdLast = 0;
  logic respReady = 0;
  logic stretch = 0;
  logic [7:0] cmdByte = 8'h00;
  logic [7:0] respByte, sd, sc, o;
  logic cmdReady, respValid, respLast, busy, sPull, sHold;
  logic [19:0] lineIn, lineOut, lineOe;
  logic [4:0] sdaSel = 5'h02;
  logic [4:0] sclSel = 5'h03;
  int bad_count = 0;
  int checked = 0;
  int seed = 20594;
  always #12.5 clk_sys = ~clk_sys;
  initial
  begin
    #37;
    forever #80 linkClk = ~linkClk;
  end
  assign lineIn = ~(lineOe | (20'(sPull) << sdaSel) | (20'(sHold) << sclSel));
  i2c_packet_master DUT (.*);
  i2c_slave_model slv (.scl(lineIn[sclSel]), .sda(lineIn[sdaSel]),
    .stretch(stretch), .pull(sPull), .hold(sHold));
  function automatic logic [7:0] rnd(input int m);
    return 8'($unsigned($random(seed)) % m);
  endfunction : rnd
  task automatic wrap_up;
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up
  task automatic run(input logic [7:0] opt, slow, sda, scl, adr, wr, rd, err);
    logic [7:0] p[$];
    logic [7:0] r[$];
    logic [31:0] e;
    int w0, n, rx;
    logic hit, fin;
    p = '{8'h00, 8'hF8, 8'h04 + (wr + 8'h01) / 2, i2c_cmd_pkg::CMD_CODE,
      8'h00, 8'h00, opt, slow, sda, scl, adr, 8'h00, wr, rd};
    for (int k = 0; k < wr + wr % 2; k++)
      p.push_back(k < wr ? 8'($random(seed)) : 8'h00);
    hit = err == 8'h00 && adr[7:1] == 7'h50;
    rx = err == 8'h00 ? int'(rd) : 0;
    if (err == 8'h00) {sdaSel, sclSel} = {sda[4:0], scl[4:0]};
    w0 = slv.wrN;
    foreach (p[k])
    begin
      @(negedge linkClk);
      if (k == 0) `CHK("ready", 1'b1, cmdReady)
      {cmdByte, cmdValid, cmdLast} = {p[k], 1'b1, k == p.size() - 1};
      @(posedge linkClk);
    end
    @(negedge linkClk);
    {cmdValid, cmdLast, n} = '0;
    do
    begin
      @(negedge linkClk);
      respReady = 1'($random(seed));
      if (respValid && respReady) r.push_back(respByte);
      fin = respValid && respReady && respLast;
      n++;
      @(posedge linkClk);
    end
    while (!fin && n < 40000);
    `CHK("finished", 1'b1, fin)
    `CHK("error", err, r[6])
    `CHK("code", i2c_cmd_pkg::CMD_CODE, r[3])
    `CHK("length", 8'(3 + (rx + 1) / 2), r[2])
    `CHK("size", 12 + 2 * ((rx + 1) / 2), r.size())
    e = hit && (wr > 0 || rd == 0) ? (32'h0000_0002 << wr) - 1 : 0;
    `CHK("acks", e, {r[11], r[10], r[9], r[8]})
    `CHK("written", hit ? int'(wr) : 0, slv.wrN - w0)
    if (hit && wr > 0) `CHK("last", p[13 + wr], slv.last)
    for (int k = 0; k < rx + rx % 2; k++)
      `CHK("read", k < rx ? 8'hA5 + 8'(k) : 8'h00, r[12 + k])
  endtask : run
  initial
  begin
    repeat (20) @(posedge clk_sys);
    @(negedge clk_sys);
    rstn = 1;
    run(8'h00, 8'h00, 8'h02, 8'h03, 8'hA1, 8'h03, 8'h02, 8'h00);
    stretch = 1;
    run(8'h16, 8'h01, 8'h13, 8'h00, 8'hA0, 8'h02, 8'h03, 8'h00);
    stretch = 0;
    run(8'h00, 8'h00, 8'h05, 8'h06, 8'h22, 8'h02, 8'h00, 8'h00);
    run(8'h00, 8'h00, 8'h04, 8'h04, 8'hA0, 8'h01, 8'h01, 8'h60);
    run(8'h00, 8'h00, 8'h14, 8'h01, 8'hA0, 8'h01, 8'h01, 8'h60);
    run(8'h00, 8'h00, 8'h01, 8'h02, 8'hA0, 8'h33, 8'h00, 8'h05);
    run(8'h00, 8'h00, 8'h01, 8'h02, 8'hA0, 8'h00, 8'h35, 8'h05);
    repeat (2)
    begin
      sd = rnd(20);
      sc = 8'((sd + 8'h01 + rnd(19)) % 20);
      o = rnd(256) & 8'h16;
      stretch = o[4];
      run(o, rnd(4), sd, sc, 8'hA0 | rnd(2), rnd(3), rnd(3), 8'h00);
    end
    wrap_up();
  end
  // span covers all runs at the slowest scl used here
  initial
  begin
    #2_500_000;
    bad_count++;
    wrap_up();
  end
endmodule : i2c_packet_master_tb_top
